/* spdi_consts.vh */
`ifndef SPDI_CONSTS_VH
`define SPDI_CONSTS_VH
// ==========================================
// Clock and timing
`define SPDI_CLK_MHZ          25
`define SPDI_DET_DELAY_US     100
`define SPDI_DET_LOW_US       260
`define SPDI_DET_WIN_US       1000
`define SPDI_SHUTDOWN_US      2500
`define SPDI_START_US         2
`define SPDI_EOS_US           2
`define SPDI_ACK_VALID_US     1
`define SPDI_ACK_HOLD_US      512
`define SPDI_DET_DELAY_CYC    (`SPDI_DET_DELAY_US * `SPDI_CLK_MHZ)
`define SPDI_DET_LOW_CYC      (`SPDI_DET_LOW_US * `SPDI_CLK_MHZ)
`define SPDI_DET_WIN_CYC      (`SPDI_DET_WIN_US * `SPDI_CLK_MHZ)
`define SPDI_SHUTDOWN_CYC     (`SPDI_SHUTDOWN_US * `SPDI_CLK_MHZ)
`define SPDI_EOS_CYC          (`SPDI_EOS_US * `SPDI_CLK_MHZ)
`define SPDI_ACK_VALID_CYC    (`SPDI_ACK_VALID_US * `SPDI_CLK_MHZ)
`define SPDI_ACK_HOLD_CYC     (`SPDI_ACK_HOLD_US * `SPDI_CLK_MHZ)
// ==========================================
// Frame layout
`define SPDI_DEV_ADDR         8'h72
`define SPDI_ACK_REQ_BIT      7
`define SPDI_SEL_HI_BIT       6
`define SPDI_SEL_LO_BIT       5
`define SPDI_SEL_LEVEL        2'h0
`define SPDI_SEL_EMI          2'h2
`define SPDI_UNLOCK_PATTERN   7'h6a
`define SPDI_LEVEL_RESET      5'h1f
`define SPDI_EMI_RESET        2'h0
`define SPDI_REF_FULL_MV      8'hc8
`endif

/* spdi_bit_decoder.v */
`timescale 1ns/1ps
`include "spdi_consts.vh"
module spdi_bit_decoder (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Control
  input  wire        enable,
  input  wire        pin,
  // Decoded bits
  output reg         bit_valid,
  output reg         bit_value,
  output reg         bit_error,
  output reg         eos,
  output reg         last_fall
);
  // ==========================================
  // Low and high time measurement
  // Counters saturate; a high longer than this is caught as end of stream first, and a low this long as shutdown.
  reg  [15:0] low_cnt;
  reg  [15:0] high_cnt;
  reg         pin_q;
  reg         in_bit;
  wire        fall = pin_q & ~pin;
  wire [16:0] low_x2  = {low_cnt, 1'b0};
  wire [16:0] high_x2 = {high_cnt, 1'b0};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt   <= 16'h0000;
      high_cnt  <= 16'h0000;
      pin_q     <= 1'b1;
      in_bit    <= 1'b0;
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      bit_error <= 1'b0;
      eos       <= 1'b0;
      last_fall <= 1'b0;
    end else begin
      pin_q     <= pin;
      bit_valid <= 1'b0;
      bit_error <= 1'b0;
      eos       <= 1'b0;
      last_fall <= 1'b0;
      if (!enable) begin
        in_bit   <= 1'b0;
        low_cnt  <= 16'h0000;
        high_cnt <= 16'h0000;
      end else if (fall) begin
        last_fall <= 1'b1;
        if (in_bit) begin
          if ({1'b0, high_cnt} >= low_x2) begin
            bit_valid <= 1'b1;
            bit_value <= 1'b1;
          end else if ({1'b0, low_cnt} >= high_x2) begin
            bit_valid <= 1'b1;
            bit_value <= 1'b0;
          end else begin
            bit_error <= 1'b1;
          end
        end
        in_bit   <= 1'b1;
        low_cnt  <= 16'h0001;
        high_cnt <= 16'h0000;
      end else if (in_bit) begin
        if (pin) begin
          if (high_cnt != 16'hffff)
            high_cnt <= high_cnt + 16'h0001;
          // A long high with no falling edge closes the byte.
          if (high_cnt == `SPDI_EOS_CYC) begin
            eos    <= 1'b1;
            in_bit <= 1'b0;
          end
        end else if (high_cnt != 16'h0000) begin
          // Low after the high half: the last bit ends only with a falling edge.
        end else if (low_cnt != 16'hffff) begin
          low_cnt <= low_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

/* spdi_level_map.v */
`timescale 1ns/1ps
`include "spdi_consts.vh"
module spdi_level_map (
  // Level code in
  input  wire [4:0] level_code,
  // Reference out
  output wire [7:0] ref_mv
);
  function [7:0] code_to_mv;
    input [4:0] code;
    begin
      if (code == 5'h00)
        code_to_mv = 8'h00;
      else if (code <= 5'h0c)
        code_to_mv = 8'h02 + {3'h0, code} * 8'h03;
      else if (code <= 5'h17)
        code_to_mv = 8'h26 + ({3'h0, code} - 8'h0c) * 8'h06;
      else
        code_to_mv = 8'h68 + ({3'h0, code} - 8'h17) * 8'h0c;
    end
  endfunction
  assign ref_mv = code_to_mv(level_code);
endmodule

/* spdi_top.v */
`timescale 1ns/1ps
`include "spdi_consts.vh"
// Notes on behaviour
// - Mode chosen each enable; default duty-cycle.
// - First rising edge enables, opens 1 ms window.
// - Low over 260 us after 100 us: serial.
// - Serial frames accepted immediately, window running.
// - Mode fixed until 2.5 ms low shutdown.
// - Constant high gives full 200 mV reference.
// - Reference gated by pulse, then low-pass filtered.
// - Serial command picks one of 32 steps.
// - Code to millivolt stepped mapping.
// - Level defaults to 31; shutdown restores it.
// - Address byte then data; address 72h only.
// - Data: ack flag, select bits, level code.
// - Bits sent most significant first.
// - End-of-stream of 2 us closes byte.
// - Bit value from high/low time ratio.
// - Ack only on request, match, 16 bits.
// - Pulldown after valid delay, at most 512 us.
// - Line released when acknowledge period ends.
// - Select 10 writes 2-bit tuning field.
// - Tuning write needs preceding unlock write.
module spdi_top (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Control pin, open drain
  input  wire       ctrl_in,
  output wire       ack_pulldown,
  output wire       ctrl_oe,
  // Status and regulation target
  output reg        enabled,
  output reg        serial_mode,
  output reg  [4:0] level_code,
  output reg  [1:0] emission_tuning_field,
  output reg        ref_gate,
  output reg  [7:0] feedback_node_ref_mv
);
  // ==========================================
  // Pin synchroniser
  reg        sync1;
  reg        pin;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      pin   <= 1'b0;
    end else begin
      sync1 <= ctrl_in;
      pin   <= sync1;
    end
  end

  // ==========================================
  // Enable, shutdown and mode detection
  localparam [1:0] MODE_OFF    = 2'h0;
  localparam [1:0] MODE_DETECT = 2'h1;
  localparam [1:0] MODE_RUN    = 2'h2;

  reg  [1:0]  mode_state;
  reg  [15:0] win_cnt;
  reg  [15:0] low_cnt;
  reg  [16:0] sd_cnt;
  reg         pin_q;
  wire        rise = pin & ~pin_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_state  <= MODE_OFF;
      win_cnt     <= 16'h0000;
      low_cnt     <= 16'h0000;
      sd_cnt      <= 17'h00000;
      pin_q       <= 1'b0;
      enabled     <= 1'b0;
      serial_mode <= 1'b0;
    end else begin
      pin_q <= pin;
      if (pin || ack_pulldown)
        sd_cnt <= 17'h00000;
      else if (sd_cnt != `SPDI_SHUTDOWN_CYC)
        sd_cnt <= sd_cnt + 17'h00001;
      case (mode_state)
        MODE_OFF: begin
          enabled     <= 1'b0;
          serial_mode <= 1'b0;
          if (rise) begin
            mode_state <= MODE_DETECT;
            enabled    <= 1'b1;
            win_cnt    <= 16'h0000;
            low_cnt    <= 16'h0000;
          end
        end
        MODE_DETECT: begin
          if (win_cnt != 16'hffff)
            win_cnt <= win_cnt + 16'h0001;
          if (!pin && win_cnt >= `SPDI_DET_DELAY_CYC)
            low_cnt <= low_cnt + 16'h0001;
          else
            low_cnt <= 16'h0000;
          if (low_cnt == `SPDI_DET_LOW_CYC && win_cnt <= `SPDI_DET_WIN_CYC) begin
            serial_mode <= 1'b1;
            mode_state  <= MODE_RUN;
          end else if (win_cnt > `SPDI_DET_WIN_CYC) begin
            mode_state <= MODE_RUN;
          end
        end
        default: begin
          // The mode only changes through shutdown.
          if (sd_cnt == `SPDI_SHUTDOWN_CYC) begin
            mode_state  <= MODE_OFF;
            enabled     <= 1'b0;
            serial_mode <= 1'b0;
          end
        end
      endcase
      if (mode_state == MODE_DETECT && sd_cnt == `SPDI_SHUTDOWN_CYC)
        mode_state <= MODE_OFF;
    end
  end

  // ==========================================
  // Bit decoding, active once serial mode is chosen
  wire bit_valid;
  wire bit_value;
  wire bit_error;
  wire eos;
  wire last_fall;

  spdi_bit_decoder u_bits (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (serial_mode & ~ack_pulldown),
    .pin       (pin),
    .bit_valid (bit_valid),
    .bit_value (bit_value),
    .bit_error (bit_error),
    .eos       (eos),
    .last_fall (last_fall)
  );

  // ==========================================
  // Frame assembly
  // Eight bits are followed by a falling edge that closes the eighth bit, so a byte
  // is complete when end of stream arrives with exactly eight decoded bits.
  reg  [7:0] shift;
  reg  [3:0] nbits;
  reg        bad;
  reg        have_addr;
  reg        addr_ok;
  reg        unlocked;
  reg        ack_pending;
  reg [15:0] ack_cnt;
  reg        ack_on;

  wire [7:0] data_byte = shift;
  wire [1:0] sel       = {data_byte[`SPDI_SEL_HI_BIT], data_byte[`SPDI_SEL_LO_BIT]};
  wire       byte_ok   = eos && !bad && nbits == 4'h8;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift                 <= 8'h00;
      nbits                 <= 4'h0;
      bad                   <= 1'b0;
      have_addr             <= 1'b0;
      addr_ok               <= 1'b0;
      unlocked              <= 1'b0;
      level_code            <= `SPDI_LEVEL_RESET;
      emission_tuning_field <= `SPDI_EMI_RESET;
      ack_pending           <= 1'b0;
    end else if (!enabled) begin
      shift                 <= 8'h00;
      nbits                 <= 4'h0;
      bad                   <= 1'b0;
      have_addr             <= 1'b0;
      addr_ok               <= 1'b0;
      unlocked              <= 1'b0;
      level_code            <= `SPDI_LEVEL_RESET;
      emission_tuning_field <= `SPDI_EMI_RESET;
      ack_pending           <= 1'b0;
    end else begin
      ack_pending <= 1'b0;
      if (bit_valid) begin
        shift <= {shift[6:0], bit_value};
        if (nbits != 4'hf)
          nbits <= nbits + 4'h1;
      end
      if (bit_error)
        bad <= 1'b1;
      if (eos) begin
        nbits <= 4'h0;
        bad   <= 1'b0;
        if (!have_addr) begin
          have_addr <= 1'b1;
          addr_ok   <= byte_ok && shift == `SPDI_DEV_ADDR;
        end else begin
          have_addr <= 1'b0;
          if (byte_ok && addr_ok) begin
            unlocked <= (data_byte[6:0] == `SPDI_UNLOCK_PATTERN);
            if (sel == `SPDI_SEL_LEVEL)
              level_code <= data_byte[4:0];
            else if (sel == `SPDI_SEL_EMI && unlocked)
              emission_tuning_field <= data_byte[1:0];
            ack_pending <= data_byte[`SPDI_ACK_REQ_BIT];
          end
        end
      end
    end
  end

  // ==========================================
  // Acknowledge
  // The final falling edge is only known as final once end of stream is seen, so the
  // pulldown starts the valid delay after that; the line has already been high for 2 us.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_cnt <= 16'h0000;
      ack_on  <= 1'b0;
    end else if (!enabled) begin
      ack_cnt <= 16'h0000;
      ack_on  <= 1'b0;
    end else if (ack_pending) begin
      ack_cnt <= 16'h0001;
      ack_on  <= 1'b0;
    end else if (ack_cnt != 16'h0000) begin
      ack_cnt <= ack_cnt + 16'h0001;
      if (ack_cnt == `SPDI_ACK_VALID_CYC)
        ack_on <= 1'b1;
      if (ack_cnt == `SPDI_ACK_VALID_CYC + `SPDI_ACK_HOLD_CYC) begin
        ack_on  <= 1'b0;
        ack_cnt <= 16'h0000;
      end
    end
  end
  assign ack_pulldown = ack_on;
  assign ctrl_oe      = ack_on;

  // ==========================================
  // Reference generation
  // A first-order filter with a 1/1024 weight stands in for the analog low-pass stage.
  // A lighter weight leaves too much ripple at the slowest pulse rate to track the duty cycle.
  wire [7:0]  step_mv;
  reg  [17:0] filt;

  spdi_level_map u_map (
    .level_code (level_code),
    .ref_mv     (step_mv)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_gate             <= 1'b0;
      filt                 <= 18'h00000;
      feedback_node_ref_mv <= 8'h00;
    end else begin
      if (!enabled) begin
        ref_gate             <= 1'b0;
        filt                 <= 18'h00000;
        feedback_node_ref_mv <= 8'h00;
      end else if (serial_mode) begin
        ref_gate             <= 1'b1;
        filt                 <= {step_mv, 10'h000};
        feedback_node_ref_mv <= step_mv;
      end else begin
        ref_gate <= pin;
        filt <= filt - {10'h000, filt[17:10]} + (pin ? {10'h000, `SPDI_REF_FULL_MV} : 18'h00000);
        feedback_node_ref_mv <= filt[17:10];
      end
    end
  end
endmodule

/* spdi_chk_sva.sv */
`timescale 1ns/1ps
module spdi_chk (
  // Clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // Pin
  input wire       ctrl_in,
  input wire       ack_pulldown,
  input wire       ctrl_oe,
  // Status
  input wire       enabled,
  input wire       serial_mode,
  input wire [4:0] level_code,
  input wire [1:0] emission_tuning_field,
  input wire       ref_gate,
  input wire [7:0] feedback_node_ref_mv
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Helper logic
  // The acknowledge length is too long for a repetition, so it is counted.
  reg [13:0] ack_cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ack_cnt <= 14'h0;
    else ack_cnt <= ack_pulldown ? ack_cnt + 14'h1 : 14'h0;
  end
  chk_ack_bound: assert property (ack_cnt <= 14'h3200) else $error("ack too long");
  chk_oe_pair: assert property (ctrl_oe == ack_pulldown) else $error("oe differs");
  chk_ack_cause: assert property ($rose(ack_pulldown) |-> serial_mode && $past(ctrl_in, 8) && $past(ctrl_in, 20))
    else $error("ack without frame end");
  chk_serial_on: assert property (serial_mode |-> enabled) else $error("serial while off");
  chk_mode_hold: assert property (enabled && $past(enabled) && $past(serial_mode) |-> serial_mode)
    else $error("mode lost");
  // The stored level is restored one cycle after the enable drops.
  chk_off_state: assert property (!enabled && !$past(enabled) |-> level_code == 5'h1f && !serial_mode && !ack_pulldown)
    else $error("off state wrong");
  chk_level_eos: assert property (enabled && $changed(level_code) |-> serial_mode && $past(ctrl_in, 4))
    else $error("level changed off frame");
  chk_entry_low: assert property ($rose(serial_mode) |-> !$past(ctrl_in, 5) && !$past(ctrl_in, 200))
    else $error("serial entry without low");
  chk_gate_serial: assert property (serial_mode && $past(serial_mode) |-> ref_gate) else $error("gate low");
  cover property ($rose(serial_mode));
  cover property ($rose(ack_pulldown));
  cover property ($fell(enabled));
endmodule
bind spdi_top spdi_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_in(ctrl_in), .ack_pulldown(ack_pulldown),
  .ctrl_oe(ctrl_oe), .enabled(enabled), .serial_mode(serial_mode), .level_code(level_code),
  .emission_tuning_field(emission_tuning_field), .ref_gate(ref_gate), .feedback_node_ref_mv(feedback_node_ref_mv));

/* spdi_host_model.sv */
`timescale 1ns/1ps
module spdi_host_model (
  // Clock
  input  wire clk_sys,
  // Open-drain pin
  input  wire ack_pulldown,
  output wire ctrl_in
);
  reg host_low;
  // ==========================================
  // Wired line with pull-up
  // Both sides only sink, so a push-pull clash never arises.
  assign ctrl_in = !(host_low || ack_pulldown);
  initial host_low = 1'b1;
  // Callers enter just after a rising edge and leave the same way.
  task drive(input bit lvl, input int n);
    begin
      host_low = !lvl;
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  task send_byte(input [7:0] b, input int nbits);
    int i;
    begin
      drive(1'b1, 60);
      for (i = 7; i > 7 - nbits; i--) begin
        drive(1'b0, b[i] ? 4 : 12);
        drive(1'b1, b[i] ? 12 : 4);
      end
      drive(1'b0, 4);
      drive(1'b1, 60);
    end
  endtask
endmodule

/* spdi_top_tb.sv */
`timescale 1ns/1ps
module spdi_top_tb;
  reg        clk_sys;
  reg        rst_n;
  wire       ctrl_in;
  wire       ack_pulldown;
  wire       enabled;
  wire       serial_mode;
  wire [4:0] level_code;
  wire [1:0] emission_tuning_field;
  wire       ref_gate;
  wire [7:0] fb;
  int        errors;
  int        checks_done;
  int        i;
  reg  [4:0] codes [0:6];
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  spdi_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_in(ctrl_in), .ack_pulldown(ack_pulldown), .ctrl_oe(),
    .enabled(enabled), .serial_mode(serial_mode), .level_code(level_code),
    .emission_tuning_field(emission_tuning_field), .ref_gate(ref_gate), .feedback_node_ref_mv(fb));
  spdi_host_model host (.clk_sys(clk_sys), .ack_pulldown(ack_pulldown), .ctrl_in(ctrl_in));
  // ==========================================
  // Tasks
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        errors++;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task test_done;
    begin
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      host.send_byte(a, 8);
      host.send_byte(d, 8);
      host.drive(1'b1, 40);
    end
  endtask
  task wait_ack(input bit v, input int lim);
    int n;
    begin
      for (n = 0; n < lim && ack_pulldown !== v; n++) @(posedge clk_sys);
      #1;
      check("ack_wait", ack_pulldown, v);
    end
  endtask
  function [7:0] mv(input [4:0] c);
    if (c == 5'h0) mv = 8'h00;
    else if (c <= 5'h0c) mv = 8'h02 + 8'h03 * c;
    else if (c <= 5'h17) mv = 8'h06 * c - 8'h22;
    else mv = 8'h0c * c - 8'hac;
  endfunction
  initial begin
    repeat (120000) @(posedge clk_sys);
    errors++;
    test_done;
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    errors = 0;
    checks_done = 0;
    codes = '{5'h00, 5'h01, 5'h0c, 5'h0d, 5'h17, 5'h18, 5'h1f};
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check("level_rst", level_code, 8'h1f);
    check("en_rst", enabled, 1'b0);
    host.drive(1'b1, 4000);
    check("en_dim", enabled, 1'b1);
    check("ser_dim", serial_mode, 1'b0);
    check("gate_hi", ref_gate, 1'b1);
    check("fb_full", fb >= 8'hbe, 1'b1);
    // Fastest allowed pulse rate keeps the filter ripple inside the window.
    for (i = 0; i < 16; i++) begin
      host.drive(1'b1, 62);
      host.drive(1'b0, 188);
    end
    check("fb_quarter", fb >= 8'h23 && fb <= 8'h41, 1'b1);
    check("ser_pwm", serial_mode, 1'b0);
    host.drive(1'b0, 62600);
    check("en_off", enabled, 1'b0);
    check("level_off", level_code, 8'h1f);
    host.drive(1'b1, 3000);
    host.drive(1'b0, 7000);
    check("ser_on", serial_mode, 1'b1);
    wr(8'h72, 8'h0a);
    check("level_a", level_code, 8'h0a);
    check("fb_a", fb, mv(5'h0a));
    check("no_ack", ack_pulldown, 1'b0);
    wr(8'h73, 8'h05);
    check("level_addr", level_code, 8'h0a);
    host.send_byte(8'h72, 8);
    host.send_byte(8'h05, 4);
    host.drive(1'b1, 40);
    check("level_short", level_code, 8'h0a);
    wr(8'h72, 8'h42);
    check("tune_locked", emission_tuning_field, 8'h0);
    wr(8'h72, 8'h6a);
    wr(8'h72, 8'h42);
    check("tune_set", emission_tuning_field, 8'h2);
    wr(8'h72, 8'h41);
    check("tune_relock", emission_tuning_field, 8'h2);
    check("level_keep", level_code, 8'h0a);
    for (i = 0; i < 7; i++) begin
      wr(8'h72, {3'h0, codes[i]});
      check("level_sweep", level_code, codes[i]);
      check("fb_sweep", fb, mv(codes[i]));
    end
    wr(8'h72, 8'h85);
    check("level_ack", level_code, 8'h05);
    wait_ack(1'b1, 200);
    check("line_low", ctrl_in, 1'b0);
    wait_ack(1'b0, 13000);
    check("line_free", ctrl_in, 1'b1);
    test_done;
  end
endmodule
